// ### rtl/meter_report_pkg.sv
package meter_report_pkg;

   // timing
   localparam int CLK_HZ      = 100_000_000;
   localparam int BAUD_RATE   = 19230;
   localparam int BIT_CYCLES  = CLK_HZ / BAUD_RATE;
   localparam int BIT_CNT_W   = 13;
   localparam int FRAME_BITS  = 10;
   localparam int BUF_DEPTH   = 2;

   // block layout, packet positions in send order
   localparam int PACKETS       = 14;
   localparam logic [3:0] PK_RANGE  = 4'h0;
   localparam logic [3:0] PK_DIGIT4 = 4'h1;
   localparam logic [3:0] PK_DIGIT0 = 4'h5;
   localparam logic [3:0] PK_FUNC   = 4'h6;
   localparam logic [3:0] PK_STATUS = 4'h7;
   localparam logic [3:0] PK_OPT1   = 4'h8;
   localparam logic [3:0] PK_OPT2   = 4'h9;
   localparam logic [3:0] PK_OPT3   = 4'ha;
   localparam logic [3:0] PK_OPT4   = 4'hb;
   localparam logic [3:0] PK_CR     = 4'hc;
   localparam logic [3:0] PK_LF     = 4'hd;

   // character codes
   localparam logic [6:0] FN_VOLT    = 7'h3b;
   localparam logic [6:0] FN_SMALL_I = 7'h3d;
   localparam logic [6:0] FN_MID_I   = 7'h3f;
   localparam logic [6:0] FN_FIXED_I = 7'h30;
   localparam logic [6:0] FN_MANU_I  = 7'h39;
   localparam logic [6:0] FN_OHM     = 7'h33;
   localparam logic [6:0] FN_CONT    = 7'h35;
   localparam logic [6:0] FN_DIODE   = 7'h31;
   localparam logic [6:0] FN_FREQ    = 7'h32;
   localparam logic [6:0] FN_CAP     = 7'h36;
   localparam logic [6:0] FN_TEMP    = 7'h34;
   localparam logic [6:0] FN_ADP     = 7'h3e;
   localparam logic [6:0] CODE_BASE  = 7'h30;
   localparam logic [6:0] CODE_CR    = 7'h0d;
   localparam logic [6:0] CODE_LF    = 7'h0a;
   localparam logic [2:0] FLAG_HDR   = 3'h3;
   localparam logic [2:0] FREQ_LOW_RANGES = 3'h2;

   typedef enum logic [3:0] {
      MODE_VOLT, MODE_SMALL_I, MODE_MID_I, MODE_FIXED_I, MODE_MANU_I,
      MODE_OHM, MODE_CONT, MODE_DIODE, MODE_FREQ, MODE_DUTY,
      MODE_CAP, MODE_TEMP, MODE_ADP
   } meas_mode_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } enc_state_type;

   // meter core state, one conversion result
   typedef struct packed {
      meas_mode_type   mode;
      logic [2:0]      range;
      logic [4:0][3:0] digits;
      logic            unit_celsius;
      logic            minus_sign;
      logic            low_supply_flag;
      logic            overflow_flag;
      logic            max_shown;
      logic            min_shown;
      logic            live_reading_flag;
      logic            offset_mode_flag;
      logic            signal_below_tenth;
      logic            peak_max;
      logic            peak_min;
      logic            dc_mode;
      logic            ac_mode;
      logic            auto_range;
      logic            auto_quantity_flag;
      logic            hold_mode;
      logic            smoothing_filter_flag;
   } meter_state_type;

   // four-flag packet, header in bits 6..4
   typedef struct packed {
      logic [2:0] hdr;
      logic       b3;
      logic       b2;
      logic       b1;
      logic       b0;
   } flag_packet_type;

endpackage

// ### rtl/packet_buffer.sv
module packet_buffer
   import meter_report_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire logic [6:0] in_data,
   output logic            out_valid,
   input  wire logic       out_ready,
   output logic [6:0]      out_data
);

   typedef struct packed {
      logic [BUF_DEPTH-1:0][6:0] mem;
      logic                      wr_ptr;
      logic                      rd_ptr;
      logic [1:0]                count;
   } buf_state_type;

   buf_state_type s_q, s_d;
   logic          push;
   logic          pop;

   assign in_ready  = (s_q.count != 2'd2);
   assign out_valid = (s_q.count != 2'd0);
   assign out_data  = s_q.mem[s_q.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // two-entry ring, honest full and empty
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = in_data;
         s_d.wr_ptr          = ~s_q.wr_ptr;
      end
      if (pop) begin
         s_d.rd_ptr = ~s_q.rd_ptr;
      end
      s_d.count = s_q.count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // packet_buffer

// ### rtl/serial_char_tx.sv
module serial_char_tx
   import meter_report_pkg::*;
#(
   parameter int BIT_TIME = BIT_CYCLES
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       char_valid,
   output logic            char_ready,
   input  wire logic [6:0] char_data,
   output logic            line_out,
   output logic            line_busy
);

   typedef struct packed {
      logic [BIT_CNT_W-1:0] div;
      logic                 bit_en;
      logic [3:0]           bits_left;
      logic [9:0]           shift;
      logic                 line;
   } tx_state_type;

   tx_state_type s_q, s_d;

   // ready in the last stop-bit cycle too, so chars follow back to back
   assign char_ready = (s_q.bits_left == 4'd0) ||
                       (s_q.bits_left == 4'd1 && s_q.bit_en);
   assign line_out   = s_q.line;
   assign line_busy  = !char_ready;

   // baud divider enable, frame shifter lsb first
   always_comb begin
      s_d        = s_q;
      s_d.bit_en = 1'b0;
      if (s_q.div == BIT_CNT_W'(BIT_TIME - 1)) begin
         s_d.div    = '0;
         s_d.bit_en = 1'b1;
      end else begin
         s_d.div = s_q.div + 1'b1;
      end
      if (char_valid && char_ready) begin
         s_d.shift     = {1'b1, ~^char_data, char_data, 1'b0};
         s_d.bits_left = 4'(FRAME_BITS);
         s_d.div       = BIT_CNT_W'(1);                        // start bit one bit time
         s_d.bit_en    = 1'b0;                                 // no stale enable
         s_d.line      = 1'b0;
         s_d.shift     = {1'b1, s_d.shift[9:1]};
      end else if (s_q.bit_en && s_q.bits_left != 4'd0) begin
         s_d.bits_left = s_q.bits_left - 1'b1;
         s_d.line      = (s_q.bits_left == 4'd1) ? 1'b1 : s_q.shift[0];
         s_d.shift     = {1'b1, s_q.shift[9:1]};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q      <= '0;
         s_q.line <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // serial_char_tx

// ### rtl/meter_report_packet_encoder.sv
// Summary of operation
// - function codes for voltage and the current modes
// - function codes for resistance, continuity, diode, frequency, capacitance, temp, adapter
// - frequency or duty: unit bit 1 for frequency, 0 for duty
// - temperature mode digits always carry the Celsius value
// - strap flag selects meaning of the two auto current codes
// - continuity and diode report range code 0110000
// - range code counts up from 0110000 per full-scale range
// - digit packets carry 0110000 plus digit value, msd first
// - status: 011, unit bit, sign, low supply, overflow
// - temperature unit bit 1 for Celsius, 0 for Fahrenheit
// - low supply and overflow bits follow their conditions
// - option one: 011, max, min, live flags in bits 3, 2, 0
// - option one bit 1 set in relative or zero-offset mode
// - option two: 011, under-range, peak max, peak min, 0
// - under-range in two lowest frequency ranges or low duty
// - option three: 011, dc, ac, auto ranging, auto quantity
// - option four: 0110, bit 2 set when strap tied low
// - option four bit 1 hold, bit 0 smoothing filter
// - carriage return code 0001101
// - line feed code 0001010
// - start 0, seven bits lsb first, odd parity, stop 1, idle 1
// - line rate 19230 baud
// - one fourteen-packet block per conversion, ending in CR LF; a conversion arriving in ST_SEND gets no block and pulses block_dropped
// - report carries live input value even while held
module meter_report_packet_encoder
   import meter_report_pkg::*;
#(
   parameter int BIT_TIME = BIT_CYCLES
) (
   input  wire logic            clk_sys,
   input  wire logic            resetn,
   input  wire logic            current_pairing_strap_n,
   input  wire logic            conversion_done,
   input  wire meter_state_type live_state,
   input  wire logic [4:0][3:0] celsius_digits,
   output logic                 serial_report_out,
   output logic                 report_busy,
   output logic                 block_dropped
);

   // encoder state, registered as one struct
   typedef struct packed {
      enc_state_type   fsm;
      logic [3:0]      pkt_idx;
      meter_state_type snap;
      logic            snap_strap;
      logic            strap_s1;
      logic            strap_s2;
      logic            dropped;
      logic            busy;
   } enc_reg_type;

   enc_reg_type s_q, s_d;

   logic [1:0] rst_sync_q;
   logic       rst_n;
   logic       buf_in_ready;
   logic       buf_in_valid;
   logic [6:0] pkt_code;
   logic       buf_out_valid;
   logic       buf_out_ready;
   logic [6:0] buf_out_data;
   logic       tx_busy;

   // reset released through two flip-flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // function code of the captured mode
   function automatic logic [6:0] func_code(input meas_mode_type m);
      case (m)
         MODE_VOLT:    func_code = FN_VOLT;
         MODE_SMALL_I: func_code = FN_SMALL_I;
         MODE_MID_I:   func_code = FN_MID_I;
         MODE_FIXED_I: func_code = FN_FIXED_I;
         MODE_MANU_I:  func_code = FN_MANU_I;
         MODE_OHM:     func_code = FN_OHM;
         MODE_CONT:    func_code = FN_CONT;
         MODE_DIODE:   func_code = FN_DIODE;
         MODE_FREQ:    func_code = FN_FREQ;
         MODE_DUTY:    func_code = FN_FREQ;
         MODE_CAP:     func_code = FN_CAP;
         MODE_TEMP:    func_code = FN_TEMP;
         MODE_ADP:     func_code = FN_ADP;
         default:      func_code = FN_VOLT;
      endcase
   endfunction

   // range code, fixed for the single-range modes
   function automatic logic [6:0] range_code(input meter_state_type st);
      if (st.mode == MODE_CONT || st.mode == MODE_DIODE) begin
         range_code = CODE_BASE;
      end else begin
         range_code = CODE_BASE + {4'h0, st.range};
      end
   endfunction

   // numeric character for one decimal digit
   function automatic logic [6:0] digit_code(input logic [3:0] d);
      digit_code = CODE_BASE + {3'h0, d};
   endfunction

   // unit-select bit of the status packet
   function automatic logic unit_bit(input meter_state_type st);
      case (st.mode)
         MODE_FREQ: unit_bit = 1'b1;
         MODE_DUTY: unit_bit = 1'b0;
         MODE_TEMP: unit_bit = st.unit_celsius;
         default:   unit_bit = 1'b0;
      endcase
   endfunction

   // under-range: lowest two frequency ranges or low duty
   function automatic logic underrange_flag(input meter_state_type st);
      logic freq_low;
      freq_low = (st.mode == MODE_FREQ) && (st.range < FREQ_LOW_RANGES);
      underrange_flag = st.signal_below_tenth &&
                        (freq_low || st.mode == MODE_DUTY);
   endfunction

   // packet selected by the position in the block
   always_comb begin
      flag_packet_type fp;
      fp       = '0;
      fp.hdr   = FLAG_HDR;
      pkt_code = CODE_LF;
      case (s_q.pkt_idx)
         PK_RANGE: begin
            pkt_code = range_code(s_q.snap);
         end
         PK_FUNC: begin
            pkt_code = func_code(s_q.snap.mode);
         end
         PK_STATUS: begin
            fp.b3    = unit_bit(s_q.snap);
            fp.b2    = s_q.snap.minus_sign;
            fp.b1    = s_q.snap.low_supply_flag;
            fp.b0    = s_q.snap.overflow_flag;
            pkt_code = fp;
         end
         PK_OPT1: begin
            fp.b3    = s_q.snap.max_shown;
            fp.b2    = s_q.snap.min_shown;
            fp.b1    = s_q.snap.offset_mode_flag;
            fp.b0    = s_q.snap.live_reading_flag;
            pkt_code = fp;
         end
         PK_OPT2: begin
            fp.b3    = underrange_flag(s_q.snap);
            fp.b2    = s_q.snap.peak_max;
            fp.b1    = s_q.snap.peak_min;
            fp.b0    = 1'b0;
            pkt_code = fp;
         end
         PK_OPT3: begin
            fp.b3    = s_q.snap.dc_mode;
            fp.b2    = s_q.snap.ac_mode;
            fp.b1    = s_q.snap.auto_range;
            fp.b0    = s_q.snap.auto_quantity_flag;
            pkt_code = fp;
         end
         PK_OPT4: begin
            fp.b3    = 1'b0;
            fp.b2    = s_q.snap_strap;
            fp.b1    = s_q.snap.hold_mode;
            fp.b0    = s_q.snap.smoothing_filter_flag;
            pkt_code = fp;
         end
         PK_CR: begin
            pkt_code = CODE_CR;
         end
         PK_LF: begin
            pkt_code = CODE_LF;
         end
         default: begin
            // digits 4 down to 0 sit at positions 1 to 5
            if (s_q.pkt_idx >= PK_DIGIT4 && s_q.pkt_idx <= PK_DIGIT0) begin
               pkt_code = digit_code(
                  s_q.snap.digits[3'(PK_DIGIT0 - s_q.pkt_idx)]);
            end
         end
      endcase
   end

   assign buf_in_valid = (s_q.fsm == ST_SEND);

   // block sequencer: capture, then walk fourteen packets
   always_comb begin
      s_d          = s_q;
      s_d.strap_s1 = current_pairing_strap_n;
      s_d.strap_s2 = s_q.strap_s1;
      s_d.dropped  = 1'b0;
      case (s_q.fsm)
         ST_IDLE: begin
            if (conversion_done) begin
               s_d.snap       = live_state;
               s_d.snap_strap = ~s_q.strap_s2;
               if (live_state.mode == MODE_TEMP) begin
                  s_d.snap.digits = celsius_digits;
               end
               s_d.pkt_idx = PK_RANGE;
               s_d.fsm     = ST_SEND;
            end
         end
         ST_SEND: begin
            if (conversion_done) begin
               s_d.dropped = 1'b1;
            end
            if (buf_in_ready) begin
               if (s_q.pkt_idx == PK_LF) begin
                  s_d.fsm     = ST_IDLE;
                  s_d.pkt_idx = PK_RANGE;
               end else begin
                  s_d.pkt_idx = s_q.pkt_idx + 1'b1;
               end
            end
         end
         default: begin
            s_d.fsm     = ST_IDLE;
            s_d.pkt_idx = PK_RANGE;
         end
      endcase
      s_d.busy = (s_d.fsm == ST_SEND) || buf_out_valid || tx_busy;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q     <= '0;
         s_q.fsm <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign report_busy   = s_q.busy;
   assign block_dropped = s_q.dropped;

   // two-entry buffer absorbs stalls of the serializer
   packet_buffer u_buffer (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (pkt_code),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out_data)
   );

   // character framing at the report rate
   serial_char_tx #(
      .BIT_TIME (BIT_TIME)
   ) u_tx (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .char_valid (buf_out_valid),
      .char_ready (buf_out_ready),
      .char_data  (buf_out_data),
      .line_out   (serial_report_out),
      .line_busy  (tx_busy)
   );

endmodule // meter_report_packet_encoder

// ### test/meter_report_props.sv
module meter_report_props
   import meter_report_pkg::*;
#(
   parameter int BIT_TIME = BIT_CYCLES
) (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic conversion_done,
   input  wire logic serial_report_out,
   input  wire logic report_busy,
   input  wire logic block_dropped
);
   timeunit 1ns;
   timeprecision 1ps;

   localparam int BLOCK_CYC = 140 * BIT_TIME;
   localparam int BLOCK_MAX = 140 * BIT_TIME + 8;

   logic prev_q;
   int   run_q;
   int   busy_q;

   // run length of the line level and length of the busy span
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 1'b1;
         run_q  <= 1;
         busy_q <= 0;
      end else begin
         prev_q <= serial_report_out;
         run_q  <= (serial_report_out != prev_q) ? 1 : run_q + 1;
         busy_q <= report_busy ? busy_q + 1 : 0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // line behaviour around a block
   idle_line_high_a: assert property (
      !report_busy |-> serial_report_out) else $error("line low while idle");
   start_after_capture_a: assert property (
      $rose(report_busy) |-> ##[1:4] !serial_report_out) else $error("no start bit");
   low_run_bits_a: assert property (
      (serial_report_out && !prev_q) |-> (run_q % BIT_TIME == 0))
      else $error("low run not whole bit times");
   block_length_a: assert property (
      $fell(report_busy) |-> (busy_q >= BLOCK_CYC) && (busy_q <= BLOCK_MAX))
      else $error("block length wrong");
   busy_holds_a: assert property (
      $rose(report_busy) |-> report_busy [*8]) else $error("busy too short");

   // capture and refusal
   capture_cause_a: assert property (
      $rose(report_busy) |-> $past(conversion_done)) else $error("busy without capture");
   drop_cause_a: assert property (
      block_dropped |-> $past(conversion_done) && $past(report_busy))
      else $error("drop without cause");
   drop_pulse_a: assert property (
      block_dropped |=> !block_dropped) else $error("drop pulse too long");

   block_start_c: cover property ($rose(report_busy));
   block_end_c:   cover property ($fell(report_busy));
   drop_c:        cover property (block_dropped);
endmodule // meter_report_props

// ### test/report_line_rx.sv
module report_line_rx
   import meter_report_pkg::*;
#(
   parameter int BIT_TIME = BIT_CYCLES
) (
   input  wire logic  clk_sys,
   input  wire logic  serial_report_out,
   output logic       rx_strobe,
   output logic [6:0] rx_char,
   output logic       rx_bad
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] bits;

   initial begin
      rx_strobe = 1'b0;
      rx_char   = 7'h00;
      rx_bad    = 1'b0;
   end

   // host receiver, samples each bit at its centre
   always begin
      @(negedge serial_report_out);
      repeat (BIT_TIME / 2) @(posedge clk_sys);
      rx_bad <= serial_report_out;
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_TIME) @(posedge clk_sys);
         bits[i] = serial_report_out;
      end
      repeat (BIT_TIME) @(posedge clk_sys);
      rx_bad    <= rx_bad | !serial_report_out | !(^bits);
      rx_char   <= bits[6:0];
      rx_strobe <= 1'b1;
      @(posedge clk_sys);
      rx_strobe <= 1'b0;
   end
endmodule // report_line_rx

// ### test/meter_report_packet_encoder_test.sv
module meter_report_packet_encoder_test
   import meter_report_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int BT = 8;

   logic            clk_sys;
   logic            resetn;
   logic            current_pairing_strap_n;
   logic            conversion_done;
   meter_state_type live_state;
   logic [4:0][3:0] celsius_digits;
   logic            serial_report_out;
   logic            report_busy;
   logic            block_dropped;
   logic            rx_strobe;
   logic            rx_bad;
   logic [6:0]      rx_char;
   int              n_mismatch;
   int              tests_run;
   int              seed;
   logic            drop_seen;
   logic [7:0]      got_q[$];
   logic [6:0]      exp_q[$];
   meter_state_type st;
   logic [4:0][3:0] cd;

   meter_report_packet_encoder #(.BIT_TIME(BT)) i_meter_report_packet_encoder (
      .clk_sys                 (clk_sys),
      .resetn                  (resetn),
      .current_pairing_strap_n (current_pairing_strap_n),
      .conversion_done         (conversion_done),
      .live_state              (live_state),
      .celsius_digits          (celsius_digits),
      .serial_report_out       (serial_report_out),
      .report_busy             (report_busy),
      .block_dropped           (block_dropped)
   );

   report_line_rx #(.BIT_TIME(BT)) i_report_line_rx (
      .clk_sys           (clk_sys),
      .serial_report_out (serial_report_out),
      .rx_strobe         (rx_strobe),
      .rx_char           (rx_char),
      .rx_bad            (rx_bad)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // collect received chars and refusal pulses
   always @(negedge clk_sys) begin
      if (rx_strobe === 1'b1) got_q.push_back({rx_bad, rx_char});
      if (block_dropped === 1'b1) drop_seen = 1'b1;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // reference block built from one conversion result
   task automatic expect_block(input meter_state_type s, input logic [4:0][3:0] c);
      logic [6:0] fn[13] = '{7'h3b, 7'h3d, 7'h3f, 7'h30, 7'h39, 7'h33, 7'h35,
                             7'h31, 7'h32, 7'h32, 7'h36, 7'h34, 7'h3e};
      logic [4:0][3:0] d;
      logic unit;
      logic ul;
      d    = (s.mode == MODE_TEMP) ? c : s.digits;
      unit = (s.mode == MODE_FREQ) | ((s.mode == MODE_TEMP) & s.unit_celsius);
      ul   = s.signal_below_tenth & (((s.mode == MODE_FREQ) & (s.range < 3'h2))
             | (s.mode == MODE_DUTY));
      exp_q = {};
      exp_q.push_back((s.mode == MODE_CONT || s.mode == MODE_DIODE) ?
                      7'h30 : 7'h30 + s.range);
      for (int i = 4; i >= 0; i--) exp_q.push_back(7'h30 + d[i]);
      exp_q.push_back(fn[s.mode]);
      exp_q.push_back({3'h3, unit, s.minus_sign, s.low_supply_flag, s.overflow_flag});
      exp_q.push_back({3'h3, s.max_shown, s.min_shown, s.offset_mode_flag,
                       s.live_reading_flag});
      exp_q.push_back({3'h3, ul, s.peak_max, s.peak_min, 1'h0});
      exp_q.push_back({3'h3, s.dc_mode, s.ac_mode, s.auto_range, s.auto_quantity_flag});
      exp_q.push_back({4'h6, !current_pairing_strap_n, s.hold_mode,
                       s.smoothing_filter_flag});
      exp_q.push_back(7'h0d);
      exp_q.push_back(7'h0a);
   endtask

   // send one conversion, optionally a second one mid-block, then compare
   task automatic run_block(input meter_state_type s, input logic [4:0][3:0] c, input bit drop);
      int n;
      expect_block(s, c);
      got_q     = {};
      drop_seen = 1'b0;
      live_state      = s;
      celsius_digits  = c;
      conversion_done = 1'b1;
      @(negedge clk_sys);
      conversion_done = 1'b0;
      if (drop) begin
         repeat (40 * BT) @(negedge clk_sys);
         live_state      = ~s;
         celsius_digits  = ~c;
         conversion_done = 1'b1;
         @(negedge clk_sys);
         conversion_done = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
      n = 0;
      while (report_busy !== 1'b0 && n < 200 * BT) begin
         @(negedge clk_sys);
         n++;
      end
      repeat (2 * BT) @(negedge clk_sys);
      check("char count", 8'(got_q.size()), 8'h0e);
      for (int i = 0; i < 14; i++) begin
         check("packet", got_q[i], {1'h0, exp_q[i]});
      end
      if (drop) check("drop flag", {7'h00, drop_seen}, 8'h01);
      $display("block mode %0d strap %0b drop %0b done", s.mode, current_pairing_strap_n, drop);
   endtask

   task report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // every mode with both strap levels, random flags and digits
   initial begin
      seed = 79597;
      n_mismatch = 0;
      tests_run = 0;
      resetn = 1'b0;
      conversion_done = 1'b0;
      current_pairing_strap_n = 1'b1;
      live_state = '0;
      celsius_digits = '0;
      drop_seen = 1'b0;
      repeat (16) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (8) @(negedge clk_sys);
      for (int m = 0; m < 13; m++) begin
         for (int k = 0; k < 2; k++) begin
            current_pairing_strap_n = k[0];
            repeat (4) @(negedge clk_sys);
            st = meter_state_type'(44'({$random(seed), $random(seed)}));
            st.mode = meas_mode_type'(m);
            for (int i = 0; i < 5; i++) begin
               st.digits[i] = 4'($unsigned($random(seed)) % 10);
               cd[i] = 4'($unsigned($random(seed)) % 10);
            end
            run_block(st, cd, (m == 8 || m == 9) && k == 1);
         end
      end
      report_and_stop;
   end

   // cut a hang short
   initial begin
      #600_000;
      n_mismatch++;
      $display("watchdog expired");
      report_and_stop;
   end
endmodule // meter_report_packet_encoder_test

bind meter_report_packet_encoder meter_report_props #(.BIT_TIME(BIT_TIME)) i_meter_report_props (
   .clk_sys           (clk_sys),
   .resetn            (resetn),
   .conversion_done   (conversion_done),
   .serial_report_out (serial_report_out),
   .report_busy       (report_busy),
   .block_dropped     (block_dropped)
);
